/* verilog/ccef_top.sv */
// comparator control, status and edge flag logic
`timescale 1ns/1ps
module ccef_top
  import ccef_pkg::*;
(
  input  wire logic       CLK,          // system clock, 20 MHz
  input  wire logic       RESET_N,      // async reset, active low
  input  wire logic [7:0] SFR_ADDR,     // register address
  input  wire logic [7:0] SFR_WDATA,    // write data
  input  wire logic       SFR_WR,       // write strobe
  input  wire logic       SFR_RD,       // read strobe
  output logic      [7:0] SFR_RDATA,    // read data
  input  wire logic [7:0] CROSSBAR_EN,  // crossbar enable register value
  input  wire logic       CMP_ANALOG,   // raw analog comparator result
  output logic            CMP_ON,       // analog enable
  output logic      [1:0] POS_HYST_SEL, // positive hysteresis code
  output logic      [1:0] NEG_HYST_SEL, // negative hysteresis code
  output logic      [1:0] RESP_MODE,    // response mode code
  output logic      [3:0] POS_INPUT_SEL,// positive input mux
  output logic      [3:0] NEG_INPUT_SEL,// negative input mux
  output logic      [7:0] POS_PIN_EN,   // one-hot positive pin connect
  output logic      [7:0] NEG_PIN_EN,   // one-hot negative pin connect
  output logic            CMP_RAW_OUT,  // raw output to its pin
  output logic            CMP_SYNC_OUT, // synced output to its pin
  output logic            CMP_IRQ       // interrupt request
);
  import ccef_pkg::*;

  // ****************************************
  // registers
  // ****************************************
  logic [7:0] ctrl_reg;
  logic [7:0] mode_reg;
  logic [7:0] insel_reg;
  logic       sync_q;
  logic       prev_reg;
  logic       rise_flag_reg;
  logic       fall_flag_reg;
  logic       rise_flag_next;
  logic       fall_flag_next;
  wire        wr_ctrl;
  wire        wr_mode;
  wire        wr_insel;
  wire        cmp_on;
  wire        raw_gated;
  wire        cmp_state;
  wire        rise_edge;
  wire        fall_edge;

  // ****************************************
  // address decode and edge detection
  // ****************************************
  assign wr_ctrl   = SFR_WR && (SFR_ADDR == CCEF_ADDR_CTRL);
  assign wr_mode   = SFR_WR && (SFR_ADDR == CCEF_ADDR_MODE);
  assign wr_insel  = SFR_WR && (SFR_ADDR == CCEF_ADDR_INSEL);
  assign cmp_on    = ctrl_reg[CCEF_B_ON];
  // gating before the synchroniser keeps a disabled comparator from leaking a stale level
  assign raw_gated = cmp_on & CMP_ANALOG;
  assign cmp_state = cmp_on & sync_q;
  // detector reads only the second flop; both reset low so no false edge follows reset
  assign rise_edge = sync_q & ~prev_reg;
  assign fall_edge = ~sync_q & prev_reg;

  function automatic logic [7:0] pin_decode(input logic [3:0] sel);
    pin_decode = 8'h00;
    if (!sel[CCEF_SEL_NONE])
      pin_decode[sel[2:0]] = 1'b1;
  endfunction

  // ****************************************
  // synchroniser
  // ****************************************
  ccef_sync u_sync
  (
    .CLK     (CLK),
    .RESET_N (RESET_N),
    .D       (raw_gated),
    .Q       (sync_q)
  );

  // ****************************************
  // edge flags and register file
  // ****************************************
  // sticky flags: hardware set beats a same-cycle software clear
  always_comb
  begin
    rise_flag_next = rise_flag_reg;
    fall_flag_next = fall_flag_reg;
    if (wr_ctrl)
    begin
      rise_flag_next = SFR_WDATA[CCEF_B_RISE];
      fall_flag_next = SFR_WDATA[CCEF_B_FALL];
    end
    if (rise_edge)
      rise_flag_next = 1'b1;
    if (fall_edge)
      fall_flag_next = 1'b1;
  end

  always_ff @(posedge CLK or negedge RESET_N)
  begin
    if (!RESET_N)
    begin
      ctrl_reg      <= CCEF_RST_CTRL;
      mode_reg      <= CCEF_RST_MODE;
      insel_reg     <= CCEF_RST_INSEL;
      prev_reg      <= 1'b0;
      rise_flag_reg <= 1'b0;
      fall_flag_reg <= 1'b0;
    end
    else
    begin
      if (wr_ctrl)
        ctrl_reg <= SFR_WDATA;
      if (wr_mode)
        mode_reg <= SFR_WDATA & CCEF_MODE_WMASK;
      if (wr_insel)
        insel_reg <= SFR_WDATA;
      prev_reg      <= sync_q;
      rise_flag_reg <= rise_flag_next;
      fall_flag_reg <= fall_flag_next;
    end
  end

  // ****************************************
  // read mux and outputs
  // ****************************************
  wire [7:0] ctrl_view = {cmp_on, cmp_state, rise_flag_reg, fall_flag_reg, ctrl_reg[3:0]};
  always_comb
  begin
    SFR_RDATA = 8'h00;
    if (SFR_RD)
    begin
      case (SFR_ADDR)
        CCEF_ADDR_CTRL:  SFR_RDATA = ctrl_view;
        CCEF_ADDR_MODE:  SFR_RDATA = mode_reg;
        CCEF_ADDR_INSEL: SFR_RDATA = insel_reg;
        default:         SFR_RDATA = 8'h00;
      endcase
    end
  end

  assign CMP_ON        = cmp_on;
  assign POS_HYST_SEL  = ctrl_reg[3:2];
  assign NEG_HYST_SEL  = ctrl_reg[1:0];
  assign RESP_MODE     = mode_reg[1:0];
  assign POS_INPUT_SEL = insel_reg[3:0];
  assign NEG_INPUT_SEL = insel_reg[7:4];
  assign POS_PIN_EN    = pin_decode(insel_reg[3:0]);
  assign NEG_PIN_EN    = pin_decode(insel_reg[7:4]);
  // raw path stays combinational so it works with the clock stopped
  assign CMP_RAW_OUT   = CROSSBAR_EN[CCEF_B_XB_RAW] & raw_gated;
  assign CMP_SYNC_OUT  = CROSSBAR_EN[CCEF_B_XB_SYNC] & cmp_state;
  assign CMP_IRQ       = (rise_flag_reg & mode_reg[CCEF_B_RISE_IE]) |
                         (fall_flag_reg & mode_reg[CCEF_B_FALL_IE]);

  // ****************************************
  // assertions
  // ****************************************
  default clocking cb @(posedge CLK); endclocking
  default disable iff (!RESET_N);
  AST_RISE_SET: assert property (rise_edge |=> rise_flag_reg) else $error("rise flag not set");
  AST_FALL_SET: assert property (fall_edge |=> fall_flag_reg) else $error("fall flag not set");
  AST_STICKY: assert property (rise_flag_reg && !wr_ctrl |=> rise_flag_reg) else $error("rise flag dropped");
  AST_SET_WINS: assert property (wr_ctrl && !SFR_WDATA[CCEF_B_FALL] && fall_edge |=> fall_flag_reg)
    else $error("clear beat edge");
  AST_IRQ: assert property (CMP_IRQ == ((rise_flag_reg && mode_reg[CCEF_B_RISE_IE]) ||
    (fall_flag_reg && mode_reg[CCEF_B_FALL_IE]))) else $error("irq mismatch");
  AST_OFF_LOW: assert property (!cmp_on |-> !CMP_RAW_OUT && !CMP_SYNC_OUT) else $error("pin high when off");
  AST_UNUSED: assert property (mode_reg[7:6] == 2'b00 && mode_reg[3:2] == 2'b00) else $error("unused bits set");
  AST_SYNC_LAT: assert property ((cmp_on && $stable(CMP_ANALOG)) [*3] |-> sync_q == CMP_ANALOG)
    else $error("sync latency wrong");
  AST_NONE: assert property (insel_reg[3] |-> POS_PIN_EN == 8'h00) else $error("none code connects");

  // ****************************************
  // further flag checks
  // ****************************************
  AST_STICKY_FALL: assert property (fall_flag_reg && !wr_ctrl |=> fall_flag_reg)
    else $error("fall flag dropped");
  AST_RISE_CLR: assert property (wr_ctrl && !SFR_WDATA[CCEF_B_RISE] && !rise_edge |=> !rise_flag_reg)
    else $error("rise flag not cleared");
  AST_RISE_QUIET: assert property (!rise_edge && !wr_ctrl && !rise_flag_reg |=> !rise_flag_reg)
    else $error("rise flag set without edge");
  AST_FALL_QUIET: assert property (!fall_edge && !wr_ctrl && !fall_flag_reg |=> !fall_flag_reg)
    else $error("fall flag set without edge");

  // ****************************************
  // register fields and read path
  // ****************************************
  AST_ON_WR: assert property (wr_ctrl |=> cmp_on == $past(SFR_WDATA[CCEF_B_ON]))
    else $error("enable not written");
  AST_HYST_WR: assert property (wr_ctrl |=> {POS_HYST_SEL, NEG_HYST_SEL} == $past(SFR_WDATA[3:0]))
    else $error("hysteresis not written");
  AST_MODE_WR: assert property (wr_mode |=> RESP_MODE == $past(SFR_WDATA[1:0]))
    else $error("mode not written");
  AST_STATE_RD: assert property (SFR_RD && SFR_ADDR == CCEF_ADDR_CTRL |-> SFR_RDATA[CCEF_B_STATE] == cmp_state)
    else $error("state bit wrong");
  AST_RD_IDLE: assert property (!SFR_RD |-> SFR_RDATA == 8'h00)
    else $error("read data without strobe");

  // ****************************************
  // pin routing
  // ****************************************
  AST_NONE_NEG: assert property (insel_reg[7] |-> NEG_PIN_EN == 8'h00)
    else $error("none code connects negative");
  AST_ONEHOT_POS: assert property (!insel_reg[3] |-> $onehot(POS_PIN_EN))
    else $error("positive select not one-hot");
  AST_ONEHOT_NEG: assert property (!insel_reg[7] |-> $onehot(NEG_PIN_EN))
    else $error("negative select not one-hot");
  // the raw pin must follow the analog level with no flop in between
  AST_RAW_PATH: assert property (CMP_RAW_OUT == (CROSSBAR_EN[CCEF_B_XB_RAW] && cmp_on && CMP_ANALOG))
    else $error("raw pin wrong");
  AST_SYNC_PATH: assert property (CMP_SYNC_OUT == (CROSSBAR_EN[CCEF_B_XB_SYNC] && cmp_on && sync_q))
    else $error("synced pin wrong");

  // ****************************************
  // covers
  // ****************************************
  COV_RISE: cover property (rise_edge ##1 CMP_IRQ);
  COV_FALL: cover property (fall_edge ##1 fall_flag_reg);
  COV_CLR: cover property (wr_ctrl && rise_edge);
  COV_OFF_FALL: cover property (!cmp_on && fall_edge);
  COV_IRQ_FALL: cover property (fall_flag_reg && mode_reg[CCEF_B_FALL_IE]);
endmodule

/* verilog/ccef_pkg.sv */
// constants and types shared by the comparator control block
// Overview of operation
// - latched synced output plus raw asynchronous output
// - disabled comparator forces pin outputs low
// - falling and rising edges set flags
// - edge flags stay set until software clears
// - interrupt when enabled flag is set
// - control bit 6 reads comparator state
// - control bit 7 enables comparator
// - positive hysteresis code to analog
// - negative hysteresis code to analog
// - mode bits select response time
// - unused mode bits read zero
// - each input picks one of eight pins
// - crossbar bits route raw and synced outputs
// - select code with top bit connects none
// - input select register resets to ones
package ccef_pkg;
  // ****************************************
  // register map
  // ****************************************
  localparam logic [7:0] CCEF_ADDR_CTRL   = 8'h9C;
  localparam logic [7:0] CCEF_ADDR_MODE   = 8'h9D;
  localparam logic [7:0] CCEF_ADDR_INSEL  = 8'h9F;
  localparam logic [7:0] CCEF_RST_CTRL    = 8'h00;
  localparam logic [7:0] CCEF_RST_MODE    = 8'h02;
  localparam logic [7:0] CCEF_RST_INSEL   = 8'hFF;
  localparam logic [7:0] CCEF_MODE_WMASK  = 8'h33;
  // ****************************************
  // field positions
  // ****************************************
  localparam int CCEF_B_ON      = 7;
  localparam int CCEF_B_STATE   = 6;
  localparam int CCEF_B_RISE    = 5;
  localparam int CCEF_B_FALL    = 4;
  localparam int CCEF_B_RISE_IE = 5;
  localparam int CCEF_B_FALL_IE = 4;
  localparam int CCEF_B_XB_RAW  = 5;
  localparam int CCEF_B_XB_SYNC = 4;
  localparam int CCEF_SEL_NONE  = 3;
  typedef logic [1:0] ccef_code_t;
endpackage

/* verilog/ccef_sync.sv */
// two-flop synchroniser for the comparator output
`timescale 1ns/1ps
module ccef_sync
(
  input  wire logic CLK,     // system clock
  input  wire logic RESET_N, // async reset, active low
  input  wire logic D,       // asynchronous level
  output logic      Q        // synchronised level
);
  logic meta_reg;
  always_ff @(posedge CLK or negedge RESET_N)
  begin
    if (!RESET_N)
    begin
      meta_reg <= 1'b0;
      Q        <= 1'b0;
    end
    else
    begin
      meta_reg <= D;
      Q        <= meta_reg;
    end
  end
endmodule

/* dv/ccef_cmp_model.sv */
// behavioural model of the analog comparator feeding the control block
`timescale 1ns/1ps
module ccef_cmp_model
(
  input  wire logic ON,    // analog enable from the block
  input  wire logic ABOVE, // positive input above negative input
  output logic      OUT    // comparator result
);
  // a powered-down comparator drives low, never a stale level
  assign OUT = ON & ABOVE;
endmodule

/* dv/tb.sv */
// self-checking bench for the comparator control block
`timescale 1ns/1ps
module tb;
  import ccef_pkg::*;
  logic       clk   = 1'b0;
  logic       rst_n = 1'b0;
  logic [7:0] addr  = 8'h00;
  logic [7:0] wdata = 8'h00;
  logic       wr    = 1'b0;
  logic       rd    = 1'b0;
  logic [7:0] xbar  = 8'h30;
  logic       above = 1'b0;
  logic [7:0] rdata, pos_en, neg_en;
  logic [3:0] pos_sel, neg_sel;
  logic [1:0] hp, hn, mode;
  logic       on, ana, raw, sync, irq;
  int         err_count  = 0;
  int         n_compared = 0;
  always #25 clk = ~clk;
  ccef_cmp_model cmp_u (.ON(on), .ABOVE(above), .OUT(ana));
  ccef_top dut_u (.CLK(clk), .RESET_N(rst_n), .SFR_ADDR(addr), .SFR_WDATA(wdata),
    .SFR_WR(wr), .SFR_RD(rd), .SFR_RDATA(rdata), .CROSSBAR_EN(xbar), .CMP_ANALOG(ana),
    .CMP_ON(on), .POS_HYST_SEL(hp), .NEG_HYST_SEL(hn), .RESP_MODE(mode),
    .POS_INPUT_SEL(pos_sel), .NEG_INPUT_SEL(neg_sel), .POS_PIN_EN(pos_en),
    .NEG_PIN_EN(neg_en), .CMP_RAW_OUT(raw), .CMP_SYNC_OUT(sync), .CMP_IRQ(irq));
  // ****************************************
  // helpers
  // ****************************************
  task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
    n_compared++;
    if (seen !== exp)
    begin
      err_count++;
      $display("MISMATCH %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk);
    addr = a;
    wdata = d;
    wr = 1'b1;
    @(negedge clk);
    wr = 1'b0;
  endtask
  task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
    @(negedge clk);
    addr = a;
    rd = 1'b1;
    #1;
    check("rdata", rdata, exp);
    @(negedge clk);
    rd = 1'b0;
  endtask
  // level change, then let synchroniser and detector settle
  task automatic drive_cmp(input logic lvl);
    @(negedge clk);
    above = lvl;
    repeat (4) @(negedge clk);
  endtask
  // ****************************************
  // scenarios
  // ****************************************
  task automatic t_regs;
    rd_chk(CCEF_ADDR_CTRL, 8'h00);
    rd_chk(CCEF_ADDR_MODE, 8'h02);
    rd_chk(CCEF_ADDR_INSEL, 8'hFF);
    check("pin_en", {pos_en | neg_en}, 8'h00);
    wr_reg(CCEF_ADDR_MODE, 8'hFF);
    rd_chk(CCEF_ADDR_MODE, 8'h33);
    check("mode", {6'h00, mode}, 8'h03);
    wr_reg(8'h9E, 8'hFF);
    rd_chk(8'h9E, 8'h00);
    wr_reg(CCEF_ADDR_CTRL, 8'hCE);
    check("hyst", {4'h0, hp, hn}, 8'h0E);
    rd_chk(CCEF_ADDR_CTRL, 8'h8E);
    wr_reg(CCEF_ADDR_INSEL, 8'h72);
    check("pos_en", pos_en, 8'h04);
    check("neg_en", neg_en, 8'h80);
    wr_reg(CCEF_ADDR_INSEL, 8'h8F);
    check("pin_none", {pos_en | neg_en}, 8'h00);
  endtask
  task automatic t_edges;
    wr_reg(CCEF_ADDR_MODE, 8'h20);
    wr_reg(CCEF_ADDR_CTRL, 8'h80);
    drive_cmp(1'b1);
    rd_chk(CCEF_ADDR_CTRL, 8'hE0);
    check("irq_rise", {7'h00, irq}, 8'h01);
    check("outs", {6'h00, raw, sync}, 8'h03);
    @(negedge clk);
    xbar = 8'h20;
    #1 check("xb_raw", {6'h00, raw, sync}, 8'h02);
    @(negedge clk);
    xbar = 8'h10;
    #1 check("xb_sync", {6'h00, raw, sync}, 8'h01);
    @(negedge clk);
    xbar = 8'h30;
    wr_reg(CCEF_ADDR_CTRL, 8'h80);
    check("irq_clr", {7'h00, irq}, 8'h00);
    drive_cmp(1'b0);
    rd_chk(CCEF_ADDR_CTRL, 8'h90);
    check("irq_masked", {7'h00, irq}, 8'h00);
    wr_reg(CCEF_ADDR_MODE, 8'h10);
    check("irq_fall", {7'h00, irq}, 8'h01);
    drive_cmp(1'b1);
    rd_chk(CCEF_ADDR_CTRL, 8'hF0);
    wr_reg(CCEF_ADDR_CTRL, 8'h80);
    rd_chk(CCEF_ADDR_CTRL, 8'hC0);
    wr_reg(CCEF_ADDR_CTRL, 8'h00);
    check("off_outs", {6'h00, raw, sync}, 8'h00);
    // gated level needs two flops plus the detector before the fall flag shows
    repeat (3) @(negedge clk);
    rd_chk(CCEF_ADDR_CTRL, 8'h10);
  endtask
  // ****************************************
  // sequence and verdict
  // ****************************************
  task automatic summarize;
    if (err_count == 0 && n_compared > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  initial
  begin
    repeat (3) @(negedge clk);
    rst_n = 1'b1;
    t_regs();
    t_edges();
    summarize();
  end
  initial
  begin
    #200000;
    err_count++;
    summarize();
  end
endmodule
